//--- hw/pec_pkg.sv
// package: register map, field masks and timing constants for the pin edge change block
package pec_pkg;

    // =====================================================================
    // register word indices (byte address = index * 4)
    // =====================================================================
    localparam logic [3:0] PEC_IDX_PORTA_RISE = 4'h0;
    localparam logic [3:0] PEC_IDX_PORTA_FALL = 4'h1;
    localparam logic [3:0] PEC_IDX_PORTA_FLAGS = 4'h2;
    localparam logic [3:0] PEC_IDX_PORTB_RISE = 4'h3;
    localparam logic [3:0] PEC_IDX_PORTB_FALL = 4'h4;
    localparam logic [3:0] PEC_IDX_PORTB_FLAGS = 4'h5;
    localparam logic [3:0] PEC_IDX_PORTC_RISE = 4'h6;
    localparam logic [3:0] PEC_IDX_PORTC_FALL = 4'h7;
    localparam logic [3:0] PEC_IDX_PORTC_FLAGS = 4'h8;
    localparam logic [3:0] PEC_IDX_PORTE_RISE = 4'h9;
    localparam logic [3:0] PEC_IDX_PORTE_FALL = 4'ha;
    localparam logic [3:0] PEC_IDX_PORTE_FLAGS = 4'hb;
    localparam logic [3:0] PEC_IDX_IRQEN = 4'hc;
    localparam logic [3:0] PEC_IDX_STATUS = 4'hd;

    // per-port register kinds within a group of three
    localparam int PEC_KIND_RISE = 0;
    localparam int PEC_KIND_FALL = 1;
    localparam int PEC_KIND_FLAGS = 2;
    localparam int PEC_NUM_PORTS = 4;
    localparam int PEC_NUM_PORT_REGS = 12;

    // =====================================================================
    // implemented bits per port: a, b, c (no bit 5), e (bit 3 only)
    // =====================================================================
    localparam logic [7:0] PEC_MASK_PORTA = 8'hff;
    localparam logic [7:0] PEC_MASK_PORTB = 8'hff;
    localparam logic [7:0] PEC_MASK_PORTC = 8'hdf;
    localparam logic [7:0] PEC_MASK_PORTE = 8'h08;

    // =====================================================================
    // peripheral_irq_enable_0 fields and status fields
    // =====================================================================
    localparam int PEC_IRQEN_EXT_BIT = 0;
    localparam int PEC_IRQEN_MASTER_BIT = 4;
    localparam int PEC_IRQEN_TIMER0_BIT = 5;
    localparam logic [7:0] PEC_MASK_IRQEN = 8'h31;
    localparam int PEC_STATUS_SUMMARY_BIT = 0;

    // =====================================================================
    // reset values and timing
    // =====================================================================
    localparam logic [7:0] PEC_RESET_REG = 8'h00;
    localparam logic [1:0] PEC_SYNC_WARM_CYCLES = 2'h3;

    // axi response codes
    localparam logic [1:0] PEC_RESP_OKAY = 2'h0;
    localparam logic [1:0] PEC_RESP_SLVERR = 2'h2;

endpackage : pec_pkg

//--- hw/pec_pin_sync.sv
// two-flop synchroniser and edge detector for the port pins
`timescale 1ns/1ps
`default_nettype none

module pec_pin_sync
    import pec_pkg::*;
#(
    parameter int WIDTH = 32
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // raw pins
    input wire logic [WIDTH-1:0] pins_i,
    // one-cycle edge pulses
    output logic [WIDTH-1:0] rise_o,
    output logic [WIDTH-1:0] fall_o
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] prev;
        logic [1:0] warm;
    } pec_sync_state_type;

    pec_sync_state_type state_q;
    pec_sync_state_type state_d;

    // =====================================================================
    // next state: meta feeds only sync; prev holds last sampled level
    // =====================================================================
    always_comb begin
        state_d = state_q;
        state_d.meta = pins_i;
        state_d.sync = state_q.meta;
        state_d.prev = state_q.sync;
        if (state_q.warm != PEC_SYNC_WARM_CYCLES) begin
            state_d.warm = state_q.warm + 2'h1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // edges held off until the pipeline holds real pin levels, so a pin
    // that is high at reset does not fake a rising edge
    assign rise_o = (state_q.warm == PEC_SYNC_WARM_CYCLES) ?
                    (state_q.sync & ~state_q.prev) : '0;
    assign fall_o = (state_q.warm == PEC_SYNC_WARM_CYCLES) ?
                    (~state_q.sync & state_q.prev) : '0;

endmodule : pec_pin_sync

`default_nettype wire

//--- hw/pec_axil_slave.sv
// axi4-lite slave front end: one write and one read under way at a time
`timescale 1ns/1ps
`default_nettype none

module pec_axil_slave
    import pec_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // write address and data channels
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [7:0] s_axil_awaddr,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    // write response channel
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    output logic [1:0] s_axil_bresp,
    // read channels
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    input wire logic [7:0] s_axil_araddr,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    // register file side
    output logic wr_en_o,
    output logic [7:0] wr_addr_o,
    output logic [7:0] wr_data_o,
    output logic wr_lane_o,
    input wire logic wr_hit_i,
    output logic [7:0] rd_addr_o,
    input wire logic [31:0] rd_data_i,
    input wire logic rd_hit_i
);

    typedef struct packed {
        logic aw_full;
        logic [7:0] aw_addr;
        logic w_full;
        logic [7:0] w_data;
        logic w_lane;
        logic b_valid;
        logic [1:0] b_resp;
        logic r_valid;
        logic [31:0] r_data;
        logic [1:0] r_resp;
    } pec_axi_state_type;

    pec_axi_state_type state_q;
    pec_axi_state_type state_d;

    // =====================================================================
    // handshakes: address and data are caught in either order
    // =====================================================================
    assign s_axil_awready = !state_q.aw_full && !state_q.b_valid;
    assign s_axil_wready = !state_q.w_full && !state_q.b_valid;
    assign s_axil_arready = !state_q.r_valid;
    assign wr_en_o = state_q.aw_full && state_q.w_full && !state_q.b_valid;
    assign wr_addr_o = state_q.aw_addr;
    assign wr_data_o = state_q.w_data;
    assign wr_lane_o = state_q.w_lane;
    assign rd_addr_o = s_axil_araddr;
    assign s_axil_bvalid = state_q.b_valid;
    assign s_axil_bresp = state_q.b_resp;
    assign s_axil_rvalid = state_q.r_valid;
    assign s_axil_rdata = state_q.r_data;
    assign s_axil_rresp = state_q.r_resp;

    always_comb begin
        state_d = state_q;
        if (s_axil_awvalid && s_axil_awready) begin
            state_d.aw_full = 1'b1;
            state_d.aw_addr = s_axil_awaddr;
        end
        if (s_axil_wvalid && s_axil_wready) begin
            state_d.w_full = 1'b1;
            state_d.w_data = s_axil_wdata[7:0]; // registers live in the low byte
            state_d.w_lane = s_axil_wstrb[0];
        end
        // the register file acts on wr_en_o this cycle
        if (wr_en_o) begin
            state_d.aw_full = 1'b0;
            state_d.w_full = 1'b0;
            state_d.b_valid = 1'b1;
            state_d.b_resp = wr_hit_i ? PEC_RESP_OKAY : PEC_RESP_SLVERR;
        end
        if (state_q.b_valid && s_axil_bready) begin
            state_d.b_valid = 1'b0;
        end
        if (s_axil_arvalid && s_axil_arready) begin
            state_d.r_valid = 1'b1;
            state_d.r_data = rd_hit_i ? rd_data_i : 32'h0000_0000;
            state_d.r_resp = rd_hit_i ? PEC_RESP_OKAY : PEC_RESP_SLVERR;
        end else if (state_q.r_valid && s_axil_rready) begin
            state_d.r_valid = 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

endmodule : pec_axil_slave

`default_nettype wire

//--- hw/pec_top.sv
// pin edge change interrupt block: enables, sticky flags, summary and gating
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - each port b pin sets its flag on an enabled rising or falling edge.
// - port c pins 7-6 and 4-0 set flags on enabled edges.
// - port e detects edges only on bit 3, using its own enables.
// - port c bit 5 has no storage in any register and reads zero.
// - port e bits 7-4 and 2-0 are absent and read zero.
// - enabled rising edge sets the pin flag and the summary flag.
// - enabled falling edge sets the pin flag and the summary flag.
// - an edge of a disabled polarity never sets the flag.
// - hardware sets flags, software clears them by writing zero.
// - port e detection is off while master clear or low-voltage programming is on.
// - every enable and flag bit resets to zero.
// - with master enable off, flags still set but no request goes out.
// - the summary flag is the OR of every pin flag.
// - an edge during a flag write leaves that flag set.
// - an enabled edge wakes a sleeping device when the master enable is set.
module pec_top
    import pec_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // axi4-lite register bus
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [7:0] s_axil_awaddr,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    output logic [1:0] s_axil_bresp,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    input wire logic [7:0] s_axil_araddr,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    // port pins
    input wire logic [7:0] porta_pin_n_i,
    input wire logic [7:0] portb_pin_n_i,
    input wire logic [7:0] portc_pin_n_i,
    input wire logic porte_pin_three_i,
    // configuration levels
    input wire logic master_clear_pin_enable_i,
    input wire logic low_voltage_program_enable_i,
    // towards the cpu interrupt logic
    output logic change_summary_flag_o,
    output logic change_irq_o,
    output logic wake_o,
    output logic timer0_irq_enable_o,
    output logic external_irq_enable_o
);

    // =====================================================================
    // state: twelve port registers plus the irq enable register
    // =====================================================================
    typedef struct packed {
        logic [PEC_NUM_PORT_REGS-1:0][7:0] regs;
        logic [7:0] irqen;
    } pec_top_state_type;

    pec_top_state_type state_q;
    pec_top_state_type state_d;

    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_byte;
    logic wr_lane;
    logic wr_hit;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_hit;
    logic [31:0] pins_all;
    logic [31:0] rise_all;
    logic [31:0] fall_all;
    logic porte_off;
    logic [PEC_NUM_PORTS-1:0][7:0] hit;
    logic [PEC_NUM_PORTS-1:0] flag_wr;
    logic summary;
    logic master_en;
    logic [4:0] wr_dec;
    logic [4:0] rd_dec;

    // =====================================================================
    // helpers
    // =====================================================================
    function automatic logic [7:0] port_mask(input int port);
        case (port)
            0: port_mask = PEC_MASK_PORTA;
            1: port_mask = PEC_MASK_PORTB;
            2: port_mask = PEC_MASK_PORTC;
            3: port_mask = PEC_MASK_PORTE;
            default: port_mask = 8'h00;
        endcase
    endfunction : port_mask

    // decode a byte address into a word index, with a hit flag
    function automatic logic [4:0] decode(input logic [7:0] addr);
        logic ok;
        ok = (addr[1:0] == 2'h0) && (addr[7:2] <= {2'h0, PEC_IDX_STATUS});
        decode = {ok, addr[5:2]};
    endfunction : decode

    function automatic logic [3:0] reg_index(input int port, input int kind);
        reg_index = 4'((port * 3) + kind);
    endfunction : reg_index

    // =====================================================================
    // bus front end and pin synchroniser
    // =====================================================================
    pec_axil_slave u_bus (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .s_axil_awvalid(s_axil_awvalid),
        .s_axil_awready(s_axil_awready),
        .s_axil_awaddr(s_axil_awaddr),
        .s_axil_wvalid(s_axil_wvalid),
        .s_axil_wready(s_axil_wready),
        .s_axil_wdata(s_axil_wdata),
        .s_axil_wstrb(s_axil_wstrb),
        .s_axil_bvalid(s_axil_bvalid),
        .s_axil_bready(s_axil_bready),
        .s_axil_bresp(s_axil_bresp),
        .s_axil_arvalid(s_axil_arvalid),
        .s_axil_arready(s_axil_arready),
        .s_axil_araddr(s_axil_araddr),
        .s_axil_rvalid(s_axil_rvalid),
        .s_axil_rready(s_axil_rready),
        .s_axil_rdata(s_axil_rdata),
        .s_axil_rresp(s_axil_rresp),
        .wr_en_o(wr_en),
        .wr_addr_o(wr_addr),
        .wr_data_o(wr_byte),
        .wr_lane_o(wr_lane),
        .wr_hit_i(wr_hit),
        .rd_addr_o(rd_addr),
        .rd_data_i(rd_data),
        .rd_hit_i(rd_hit)
    );

    // port e contributes bit 3 only; unused lanes are tied low
    assign pins_all = {4'h0, porte_pin_three_i, 3'h0, portc_pin_n_i, portb_pin_n_i,
                       porta_pin_n_i};

    pec_pin_sync #(
        .WIDTH(32)
    ) u_sync (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .pins_i(pins_all),
        .rise_o(rise_all),
        .fall_o(fall_all)
    );

    // =====================================================================
    // enabled edges per port; port e pin is lost to master clear or low-voltage programming
    // =====================================================================
    assign porte_off = master_clear_pin_enable_i || low_voltage_program_enable_i;

    always_comb begin
        for (int p = 0; p < PEC_NUM_PORTS; p++) begin
            // polarity gated by its own enable only
            hit[p] = ((rise_all[p*8 +: 8] & state_q.regs[reg_index(p, PEC_KIND_RISE)]) |
                      (fall_all[p*8 +: 8] & state_q.regs[reg_index(p, PEC_KIND_FALL)]))
                     & port_mask(p);
            flag_wr[p] = wr_en && wr_lane &&
                         (wr_addr[5:2] == reg_index(p, PEC_KIND_FLAGS)) &&
                         (wr_addr[1:0] == 2'h0) && (wr_addr[7:6] == 2'h0);
        end
        if (porte_off) begin
            hit[3] = 8'h00;
        end
    end

    // =====================================================================
    // register next state
    // =====================================================================
    assign wr_dec = decode(wr_addr);
    assign wr_hit = wr_dec[4] && (wr_dec[3:0] != PEC_IDX_STATUS);

    always_comb begin
        state_d = state_q;
        if (wr_en && wr_lane && wr_hit) begin
            if (wr_addr[5:2] == PEC_IDX_IRQEN) begin
                state_d.irqen = wr_byte & PEC_MASK_IRQEN;
            end else begin
                state_d.regs[wr_addr[5:2]] = wr_byte;
            end
        end
        // unimplemented bits never hold a one, and a set beats the write
        for (int p = 0; p < PEC_NUM_PORTS; p++) begin
            for (int k = 0; k < 3; k++) begin
                state_d.regs[reg_index(p, k)] =
                    state_d.regs[reg_index(p, k)] & port_mask(p);
            end
            state_d.regs[reg_index(p, PEC_KIND_FLAGS)] =
                state_d.regs[reg_index(p, PEC_KIND_FLAGS)] | hit[p];
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // =====================================================================
    // read mux and interrupt outputs
    // =====================================================================
    assign rd_dec = decode(rd_addr);
    assign rd_hit = rd_dec[4];

    always_comb begin
        rd_data = 32'h0000_0000;
        if (rd_addr[5:2] == PEC_IDX_IRQEN) begin
            rd_data[7:0] = state_q.irqen;
        end else if (rd_addr[5:2] == PEC_IDX_STATUS) begin
            rd_data[PEC_STATUS_SUMMARY_BIT] = summary;
        end else if (rd_addr[5:2] < PEC_IDX_IRQEN) begin
            rd_data[7:0] = state_q.regs[rd_addr[5:2]];
        end
    end

    assign summary = |{state_q.regs[PEC_IDX_PORTA_FLAGS], state_q.regs[PEC_IDX_PORTB_FLAGS],
                       state_q.regs[PEC_IDX_PORTC_FLAGS],
                       state_q.regs[PEC_IDX_PORTE_FLAGS]};
    assign master_en = state_q.irqen[PEC_IRQEN_MASTER_BIT];
    assign change_summary_flag_o = summary;
    // flags keep collecting with the master enable off; only the request is held
    assign change_irq_o = summary && master_en;
    // clock keeps running in sleep here, so wake is the same gated request
    assign wake_o = summary && master_en;
    assign timer0_irq_enable_o = state_q.irqen[PEC_IRQEN_TIMER0_BIT];
    assign external_irq_enable_o = state_q.irqen[PEC_IRQEN_EXT_BIT];

    // =====================================================================
    // checks
    // =====================================================================
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (reset_i);

    a_portb_edge_sets: assert property (
        (hit[1] != 8'h00) |=> ((state_q.regs[PEC_IDX_PORTB_FLAGS] & $past(hit[1]))
                                == $past(hit[1])))
        else $error("port b enabled edge did not set its flag");

    a_edge_beats_clear: assert property (
        (flag_wr[2] && hit[2] != 8'h00) |=>
        ((state_q.regs[PEC_IDX_PORTC_FLAGS] & $past(hit[2])) == $past(hit[2])))
        else $error("port c edge lost during a flag write");

    a_portc_bit5_zero: assert property (
        !state_q.regs[PEC_IDX_PORTC_RISE][5] && !state_q.regs[PEC_IDX_PORTC_FALL][5] &&
        !state_q.regs[PEC_IDX_PORTC_FLAGS][5])
        else $error("port c bit 5 holds a one");

    a_porte_unused_zero: assert property (
        ((state_q.regs[PEC_IDX_PORTE_RISE] | state_q.regs[PEC_IDX_PORTE_FALL] |
          state_q.regs[PEC_IDX_PORTE_FLAGS]) & ~PEC_MASK_PORTE) == 8'h00)
        else $error("port e unimplemented bit set");

    a_porte_gated_off: assert property (
        (porte_off && !flag_wr[3]) |=>
        (state_q.regs[PEC_IDX_PORTE_FLAGS] == $past(state_q.regs[PEC_IDX_PORTE_FLAGS])))
        else $error("port e flag changed while pin is not a port");

    a_disabled_edge_quiet: assert property (
        (hit[0] == 8'h00 && !flag_wr[0]) |=>
        $stable(state_q.regs[PEC_IDX_PORTA_FLAGS]))
        else $error("port a flag set without an enabled edge");

    a_flag_write_clear: assert property (
        (flag_wr[0] && hit[0] == 8'h00) |=>
        (state_q.regs[PEC_IDX_PORTA_FLAGS] == $past(wr_byte)))
        else $error("port a flag write not taken");

    a_summary_or: assert property (
        change_summary_flag_o == (state_q.regs[PEC_IDX_PORTA_FLAGS] != 8'h00 ||
        state_q.regs[PEC_IDX_PORTB_FLAGS] != 8'h00 ||
        state_q.regs[PEC_IDX_PORTC_FLAGS] != 8'h00 ||
        state_q.regs[PEC_IDX_PORTE_FLAGS] != 8'h00))
        else $error("summary flag is not the or of pin flags");

    a_irq_master_gate: assert property (
        (change_irq_o == (change_summary_flag_o && state_q.irqen[PEC_IRQEN_MASTER_BIT])) &&
        (wake_o == change_irq_o))
        else $error("interrupt request not gated by master enable");

    a_reset_clears_all: assert property (@(posedge clock_i) disable iff (1'b0)
        reset_i |=> (state_q == '0))
        else $error("registers not zero after reset");

endmodule : pec_top

`default_nettype wire

//--- tb/pec_pin_model.sv
// partner model: outside circuit driving the port pins
`timescale 1ns/1ps
`default_nettype none

module pec_pin_model (
    // wanted levels from the bench
    input wire logic [24:0] level_i,
    // levels on the pins
    output logic [24:0] pins_o
);
    // pins move away from the clock edge, as real ones are unrelated to it
    initial pins_o = '0;
    always @(level_i) pins_o <= #13 level_i;
endmodule : pec_pin_model

`default_nettype wire

//--- tb/pec_top_test.sv
// testbench: bus access, pin edges and request gating of the block
`timescale 1ns/1ps
`default_nettype none

module pec_top_test;
    import pec_pkg::*;
    // =======================================================================
    // signals
    logic clock_i, reset_i, s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
    logic s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready, s_axil_rvalid;
    logic s_axil_rready, change_summary_flag_o, change_irq_o, wake_o, timer0_irq_enable_o;
    logic external_irq_enable_o, master_clear_pin_enable_i, low_voltage_program_enable_i;
    logic [7:0] s_axil_awaddr, s_axil_araddr;
    logic [31:0] s_axil_wdata, s_axil_rdata, rd;
    logic [3:0] s_axil_wstrb;
    logic [1:0] s_axil_bresp, s_axil_rresp, rsp;
    logic [24:0] level, pins;
    logic [7:0] mask [4] = '{PEC_MASK_PORTA, PEC_MASK_PORTB, PEC_MASK_PORTC, PEC_MASK_PORTE};
    int fails, check_count, cycles;

    pec_top dut_u (.clock_i, .reset_i, .s_axil_awvalid, .s_axil_awready, .s_axil_awaddr,
        .s_axil_wvalid, .s_axil_wready, .s_axil_wdata, .s_axil_wstrb, .s_axil_bvalid,
        .s_axil_bready, .s_axil_bresp, .s_axil_arvalid, .s_axil_arready, .s_axil_araddr,
        .s_axil_rvalid, .s_axil_rready, .s_axil_rdata, .s_axil_rresp,
        .porta_pin_n_i(pins[7:0]), .portb_pin_n_i(pins[15:8]), .portc_pin_n_i(pins[23:16]),
        .porte_pin_three_i(pins[24]), .master_clear_pin_enable_i, .low_voltage_program_enable_i,
        .change_summary_flag_o, .change_irq_o, .wake_o, .timer0_irq_enable_o,
        .external_irq_enable_o);
    pec_pin_model pin_u (.level_i(level), .pins_o(pins));

    // =======================================================================
    // shared tasks
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // ready is sampled mid-cycle; it only moves at rising edges, so it holds at the next one
    task wr(input logic [7:0] a, input logic [7:0] d);
        logic aw_t, w_t, b_t;
        @(posedge clock_i);
        s_axil_awvalid <= 1'b1;
        s_axil_wvalid <= 1'b1;
        s_axil_awaddr <= a;
        s_axil_wdata <= {24'h0, d};
        s_axil_bready <= 1'b1;
        b_t = 1'b0;
        while (!b_t) begin
            @(negedge clock_i);
            aw_t = s_axil_awvalid && s_axil_awready;
            w_t = s_axil_wvalid && s_axil_wready;
            b_t = s_axil_bvalid;
            rsp = s_axil_bresp;
            @(posedge clock_i);
            if (aw_t) s_axil_awvalid <= 1'b0;
            if (w_t) s_axil_wvalid <= 1'b0;
        end
        s_axil_bready <= 1'b0;
    endtask : wr

    task rdr(input logic [7:0] a);
        logic ar_t, r_t;
        @(posedge clock_i);
        s_axil_arvalid <= 1'b1;
        s_axil_araddr <= a;
        s_axil_rready <= 1'b1;
        r_t = 1'b0;
        while (!r_t) begin
            @(negedge clock_i);
            ar_t = s_axil_arvalid && s_axil_arready;
            r_t = s_axil_rvalid;
            rd = s_axil_rdata;
            rsp = s_axil_rresp;
            @(posedge clock_i);
            if (ar_t) s_axil_arvalid <= 1'b0;
        end
        s_axil_rready <= 1'b0;
    endtask : rdr

    task rchk(input logic [7:0] a, input logic [7:0] exp);
        rdr(a);
        chk(rd, {24'h0, exp});
    endtask : rchk

    // a pin change shows in its flag three edges later; six leaves margin
    task pin(input logic [24:0] v);
        level <= v;
        repeat (6) @(posedge clock_i);
    endtask : pin

    // =======================================================================
    // scenarios
    task t_reset;
        for (int i = 0; i < 14; i++) rchk(8'(i * 4), 8'h00);
        rdr(8'h38);
        chk(rsp, PEC_RESP_SLVERR);
        wr(8'h34, 8'h01);
        chk(rsp, PEC_RESP_SLVERR);
    endtask : t_reset

    task t_regs;
        for (int i = 0; i < 12; i++) begin
            wr(8'(i * 4), 8'hff);
            rchk(8'(i * 4), mask[i / 3]);
        end
        chk({change_summary_flag_o, change_irq_o}, 2'h2);
        wr(8'h30, 8'hff);
        rchk(8'h30, PEC_MASK_IRQEN);
        chk({timer0_irq_enable_o, external_irq_enable_o, wake_o}, 3'h7);
        for (int i = 0; i < 13; i++) wr(8'(i * 4), 8'h00);
        chk({change_summary_flag_o, change_irq_o}, 2'h0);
    endtask : t_regs

    task t_edges;
        wr(8'h0c, 8'h01);
        wr(8'h10, 8'h02);
        pin(25'h0000300);
        rchk(8'h14, 8'h01);
        chk({change_summary_flag_o, change_irq_o}, 2'h2);
        pin(25'h0);
        rchk(8'h14, 8'h03);
        wr(8'h30, 8'h10);
        chk({change_irq_o, wake_o}, 2'h3);
        wr(8'h14, 8'h00);
        chk({change_summary_flag_o, wake_o}, 2'h0);
    endtask : t_edges

    task t_portce;
        wr(8'h18, 8'hff);
        pin(25'h0ff0000);
        rchk(8'h20, 8'hdf);
        wr(8'h24, 8'hff);
        master_clear_pin_enable_i <= 1'b1;
        pin(25'h1ff0000);
        rchk(8'h2c, 8'h00);
        master_clear_pin_enable_i <= 1'b0;
        pin(25'h0ff0000);
        low_voltage_program_enable_i <= 1'b1;
        pin(25'h1ff0000);
        rchk(8'h2c, 8'h00);
        low_voltage_program_enable_i <= 1'b0;
        pin(25'h0ff0000);
        pin(25'h1ff0000);
        rchk(8'h2c, 8'h08);
    endtask : t_portce

    // port c bit 0 falls so its pulse meets the clearing write on the same edge
    task t_race;
        wr(8'h1c, 8'hff);
        level <= 25'h1fe0000;
        wr(8'h20, 8'h00);
        rchk(8'h20, 8'h01);
    endtask : t_race

    task test_done;
        $display("mismatches %0d, comparisons %0d", fails, check_count);
        if (fails == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    // =======================================================================
    // clock, watchdog and main sequence
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end

    // runaway guard, far above the few hundred cycles the run needs
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            test_done;
        end
    end

    initial begin
        {s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid, s_axil_rready} = '0;
        {s_axil_awaddr, s_axil_araddr, s_axil_wdata} = '0;
        {master_clear_pin_enable_i, low_voltage_program_enable_i} = '0;
        s_axil_wstrb = 4'h1;
        level = '0;
        fails = 0;
        check_count = 0;
        cycles = 0;
        reset_i = 1'b1;
        repeat (10) @(posedge clock_i);
        reset_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        t_reset;
        t_regs;
        t_edges;
        t_portce;
        t_race;
        test_done;
    end
endmodule : pec_top_test

`default_nettype wire
